/* File: cts_pkg.sv */
// Operation
// - Internal RC codes 0001..0100 select 1, 2, 4 and 8 MHz nominal.
// - Default fuses pick 1 MHz internal RC with start-up setting 10.
// - Every reset copies the factory 1 MHz calibration byte into trim.
// - Internal RC wakes in 6 cycles; reset delay none, 4.1 ms, 65 ms.
// - Clock-source code 0000 selects the external clock on the input pin.
// - External clock wakes in 6 cycles; reset delay none, 4.1 ms, 65 ms.
// - Trim value sets RC frequency monotonically, zero lowest, all ones top.
// - Software may write the trim register at run time.
// - Watchdog and reset time-out run from the watchdog oscillator tick.
// - Low-power instruction sleeps only when the allow bit is one.
// - Mode select bits live in status, control and extended registers.
// - Interrupt wake stalls four cycles past start-up, then resumes.
// - Waking leaves register file and SRAM contents untouched.
// - Reset during sleep wakes and restarts from the reset vector.
// - Mode codes 000 Idle, 010 Power-down, 110 Standby; rest reserved.
// - Standby keeps the oscillator and resumes after six start-up cycles plus the four-cycle stall.
package cts_pkg;

   // Register offsets on the plain port.
   localparam logic [3:0] CTS_ADDR_TRIM = 4'h0;
   localparam logic [3:0] CTS_ADDR_MCUCTL = 4'h1;
   localparam logic [3:0] CTS_ADDR_MCUSTAT = 4'h2;
   localparam logic [3:0] CTS_ADDR_EXTCTL = 4'h3;
   localparam logic [3:0] CTS_ADDR_STATE = 4'h4;

   // Field positions.
   localparam int CTS_BIT_ALLOW = 5;
   localparam int CTS_BIT_SEL_MID = 4;
   localparam int CTS_BIT_SEL_HI = 5;
   localparam int CTS_BIT_SEL_LO = 7;

   // Reset values.
   localparam logic [7:0] CTS_RST_MCUCTL = 8'h00;
   localparam logic [7:0] CTS_RST_MCUSTAT = 8'h00;
   localparam logic [7:0] CTS_RST_EXTCTL = 8'h00;

   // Fuse codes.
   localparam logic [3:0] CTS_SRC_EXT = 4'h0;
   localparam logic [3:0] CTS_SRC_RC1 = 4'h1;
   localparam logic [3:0] CTS_SRC_RC2 = 4'h2;
   localparam logic [3:0] CTS_SRC_RC4 = 4'h3;
   localparam logic [3:0] CTS_SRC_RC8 = 4'h4;
   localparam logic [1:0] CTS_SUT_NONE = 2'h0;
   localparam logic [1:0] CTS_SUT_SHORT = 2'h1;
   localparam logic [1:0] CTS_SUT_LONG = 2'h2;
   localparam logic [3:0] CTS_DFLT_SRC = CTS_SRC_RC1;
   localparam logic [1:0] CTS_DFLT_SUT = CTS_SUT_LONG;

   // Sleep mode codes.
   localparam logic [2:0] CTS_MODE_IDLE = 3'h0;
   localparam logic [2:0] CTS_MODE_PDOWN = 3'h2;
   localparam logic [2:0] CTS_MODE_STBY = 3'h6;

   // Timing.
   localparam int CTS_CLK_MHZ = 100;
   localparam int CTS_WAKE_CK = 6;
   localparam int CTS_IRQ_STALL_CK = 4;
   localparam int CTS_STBY_CK = 6;
   localparam int CTS_SHORT_US = 4100;
   localparam int CTS_LONG_US = 65000;
   localparam int CTS_SHORT_CYC = CTS_SHORT_US * CTS_CLK_MHZ;
   localparam int CTS_LONG_CYC = CTS_LONG_US * CTS_CLK_MHZ;

   typedef enum logic [2:0] {
      CTS_ST_RUN = 3'b000,
      CTS_ST_SLEEP = 3'b001,
      CTS_ST_START = 3'b010,
      CTS_ST_STALL = 3'b011,
      CTS_ST_RESET = 3'b100
   } cts_state_t;

   typedef struct packed {
      logic [3:0] src;
      logic [1:0] startup_time_fuses;
      logic cap_opt;
   } cts_fuse_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } cts_bus_t;

   function automatic logic cts_is_rc(input logic [3:0] src);
      cts_is_rc = (src >= CTS_SRC_RC1) && (src <= CTS_SRC_RC8);
   endfunction : cts_is_rc

endpackage : cts_pkg

/* File: cts_sync.sv */
`timescale 1ns/1ps
module cts_sync import cts_pkg::*; #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Asynchronous in, synchronous out.
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_o = sync_q;
endmodule : cts_sync

/* File: cts_delay.sv */
`timescale 1ns/1ps
module cts_delay import cts_pkg::*; #(
   parameter int WIDTH = 32
) (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Load and count.
   input wire logic load_i,
   input wire logic [WIDTH-1:0] count_i,
   input wire logic tick_i,
   output logic done_o
);
   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;

   always_comb begin
      cnt_d = cnt_q;
      if (load_i) begin
         cnt_d = count_i;
      end else if (tick_i && (cnt_q != '0)) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign done_o = (cnt_q == '0) && !load_i;
endmodule : cts_delay

/* File: cts_top.sv */
`timescale 1ns/1ps
module cts_top import cts_pkg::*; #(
   parameter int SHORT_CYC = CTS_SHORT_CYC,
   parameter int LONG_CYC = CTS_LONG_CYC
) (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Non-volatile fuses and factory calibration byte.
   input wire logic [3:0] clock_source_select_fuses_i,
   input wire logic [1:0] startup_time_fuses_i,
   input wire logic oscillator_option_fuse_i,
   input wire logic [7:0] factory_cal_i,
   // External clock pin, sampled, and watchdog oscillator tick.
   input wire logic osc_input_pin_i,
   input wire logic wdt_osc_tick_i,
   // Core events.
   input wire logic sleep_instr_i,
   input wire logic irq_i,
   // Register port.
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Clock control outputs.
   output logic [7:0] trim_value_o,
   output logic use_ext_clk_o,
   output logic [1:0] rc_freq_sel_o,
   output logic osc_run_o,
   output logic ext_clk_o,
   output logic core_halt_o,
   output logic core_reset_o,
   output logic irq_ack_o,
   output logic [2:0] lowpower_mode_o
);
   cts_bus_t bus;
   cts_fuse_t fuse_q;
   cts_fuse_t fuse_d;
   cts_state_t st_q;
   cts_state_t st_d;
   logic [7:0] trim_q;
   logic [7:0] trim_d;
   logic [7:0] mcuctl_q;
   logic [7:0] mcuctl_d;
   logic [7:0] mcustat_q;
   logic [7:0] mcustat_d;
   logic [7:0] extctl_q;
   logic [7:0] extctl_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [2:0] mode_q;
   logic [2:0] mode_d;
   logic [2:0] cyc_q;
   logic [2:0] cyc_d;
   logic use_ext_q;
   logic use_ext_d;
   logic [1:0] freq_q;
   logic [1:0] freq_d;
   logic osc_run_q;
   logic osc_run_d;
   logic halt_q;
   logic halt_d;
   logic creset_q;
   logic creset_d;
   logic ack_q;
   logic ack_d;
   logic ext_pin_s;
   logic ext_clk_q;
   logic ext_clk_d;
   logic armed_q;
   logic armed_d;
   logic [2:0] mode_sel;
   logic dly_load;
   logic [31:0] dly_count;
   logic dly_done;

   // Only the three defined sleep codes count; the rest act as a no-op.
   function automatic logic mode_legal(input logic [2:0] m);
      mode_legal = (m == CTS_MODE_IDLE) || (m == CTS_MODE_PDOWN) ||
                   (m == CTS_MODE_STBY);
   endfunction : mode_legal

   assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i,
                  wr: reg_wr_i, rd: reg_rd_i};
   assign mode_sel = {mcustat_q[CTS_BIT_SEL_HI],
                      mcuctl_q[CTS_BIT_SEL_MID],
                      extctl_q[CTS_BIT_SEL_LO]};

   cts_sync #(.WIDTH(1)) u_pin_sync (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .async_i(osc_input_pin_i),
      .sync_o(ext_pin_s)
   );

   // Reset time-out counts watchdog oscillator ticks, not the system clock.
   cts_delay #(.WIDTH(32)) u_delay (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .load_i(dly_load),
      .count_i(dly_count),
      .tick_i(wdt_osc_tick_i),
      .done_o(dly_done)
   );

   // Fuses are caught on every cycle of the reset phase and held once it ends.
   always_comb begin
      fuse_d = fuse_q;
      armed_d = (st_q == CTS_ST_RESET);
      if (st_q == CTS_ST_RESET) begin
         fuse_d = '{src: clock_source_select_fuses_i,
                    startup_time_fuses: startup_time_fuses_i,
                    cap_opt: oscillator_option_fuse_i};
      end
   end

   always_comb begin
      dly_load = 1'b0;
      dly_count = 32'h0000_0000;
      // Loaded once on entry, so that the count can then run down.
      if (st_q == CTS_ST_RESET && !armed_q) begin
         dly_load = 1'b1;
         unique case (startup_time_fuses_i)
            CTS_SUT_SHORT: dly_count = 32'(SHORT_CYC);
            CTS_SUT_LONG: dly_count = 32'(LONG_CYC);
            default: dly_count = 32'h0000_0000;
         endcase
      end
   end

   // Software-visible registers; the reset phase reloads the factory trim.
   always_comb begin
      trim_d = trim_q;
      mcuctl_d = mcuctl_q;
      mcustat_d = mcustat_q;
      extctl_d = extctl_q;
      rdata_d = 8'h00;
      if (bus.wr) begin
         unique case (bus.addr)
            CTS_ADDR_TRIM: trim_d = bus.wdata;
            CTS_ADDR_MCUCTL: mcuctl_d = bus.wdata;
            CTS_ADDR_MCUSTAT: mcustat_d = bus.wdata;
            CTS_ADDR_EXTCTL: extctl_d = bus.wdata;
            default: ;
         endcase
      end
      if (bus.rd) begin
         unique case (bus.addr)
            CTS_ADDR_TRIM: rdata_d = trim_q;
            CTS_ADDR_MCUCTL: rdata_d = mcuctl_q;
            CTS_ADDR_MCUSTAT: rdata_d = mcustat_q;
            CTS_ADDR_EXTCTL: rdata_d = extctl_q;
            // The state view packs option fuse, source, state and rate.
            CTS_ADDR_STATE: rdata_d = {fuse_q.cap_opt, 1'b0, use_ext_q, st_q,
                                       freq_q};
            default: rdata_d = 8'h00;
         endcase
      end
      if (st_q == CTS_ST_RESET) begin
         trim_d = factory_cal_i;
      end
   end

   // Clock selection and sleep sequencing.
   always_comb begin
      st_d = st_q;
      mode_d = mode_q;
      cyc_d = cyc_q;
      halt_d = halt_q;
      creset_d = 1'b0;
      ack_d = 1'b0;
      osc_run_d = 1'b1;
      use_ext_d = (fuse_q.src == CTS_SRC_EXT);
      freq_d = freq_q;
      if (cts_is_rc(fuse_q.src)) begin
         freq_d = 2'(fuse_q.src - CTS_SRC_RC1);
      end
      // The pin reaches the clock output only with the external source.
      ext_clk_d = ext_pin_s & use_ext_d;
      unique case (st_q)
         CTS_ST_RESET: begin
            halt_d = 1'b1;
            creset_d = 1'b1;
            // Hold the core until the start-up delay has run out.
            if (dly_done) begin
               st_d = CTS_ST_RUN;
               halt_d = 1'b0;
               creset_d = 1'b0;
            end
         end
         CTS_ST_RUN: begin
            // Reserved mode codes are ignored like a cleared allow bit.
            if (sleep_instr_i && mcuctl_q[CTS_BIT_ALLOW] &&
                mode_legal(mode_sel)) begin
               st_d = CTS_ST_SLEEP;
               mode_d = mode_sel;
               halt_d = 1'b1;
            end
         end
         CTS_ST_SLEEP: begin
            // Sleep gates the core and, in power-down, the oscillator; no storage is touched here.
            osc_run_d = (mode_q != CTS_MODE_PDOWN);
            if (irq_i) begin
               st_d = CTS_ST_START;
               cyc_d = (mode_q == CTS_MODE_PDOWN) ?
                       3'(CTS_WAKE_CK - 1) : 3'(CTS_STBY_CK - 1);
               if (mode_q == CTS_MODE_IDLE) begin
                  st_d = CTS_ST_STALL;
                  cyc_d = 3'(CTS_IRQ_STALL_CK - 1);
               end
            end
         end
         CTS_ST_START: begin
            // Oscillator restart time before the core stall.
            if (cyc_q == 3'h0) begin
               st_d = CTS_ST_STALL;
               cyc_d = 3'(CTS_IRQ_STALL_CK - 1);
            end else begin
               cyc_d = cyc_q - 3'h1;
            end
         end
         CTS_ST_STALL: begin
            // Hand control back so the core services the interrupt.
            if (cyc_q == 3'h0) begin
               st_d = CTS_ST_RUN;
               halt_d = 1'b0;
               ack_d = 1'b1;
            end else begin
               cyc_d = cyc_q - 3'h1;
            end
         end
         default: st_d = CTS_ST_RESET;
      endcase
   end

   // Fuse capture and start-up delay arming.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         fuse_q <= '{src: CTS_DFLT_SRC, startup_time_fuses: CTS_DFLT_SUT,
                     cap_opt: 1'b1};
         armed_q <= 1'b0;
      end else begin
         fuse_q <= fuse_d;
         armed_q <= armed_d;
      end
   end

   // Software-visible registers.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         trim_q <= 8'h00;
         mcuctl_q <= CTS_RST_MCUCTL;
         mcustat_q <= CTS_RST_MCUSTAT;
         extctl_q <= CTS_RST_EXTCTL;
         rdata_q <= 8'h00;
      end else begin
         trim_q <= trim_d;
         mcuctl_q <= mcuctl_d;
         mcustat_q <= mcustat_d;
         extctl_q <= extctl_d;
         rdata_q <= rdata_d;
      end
   end

   // Sequencer and clock-control outputs.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st_q <= CTS_ST_RESET;
         mode_q <= CTS_MODE_IDLE;
         cyc_q <= 3'h0;
         halt_q <= 1'b1;
         creset_q <= 1'b1;
         ack_q <= 1'b0;
         osc_run_q <= 1'b1;
         use_ext_q <= 1'b0;
         freq_q <= 2'h0;
         ext_clk_q <= 1'b0;
      end else begin
         st_q <= st_d;
         mode_q <= mode_d;
         cyc_q <= cyc_d;
         halt_q <= halt_d;
         creset_q <= creset_d;
         ack_q <= ack_d;
         osc_run_q <= osc_run_d;
         use_ext_q <= use_ext_d;
         freq_q <= freq_d;
         ext_clk_q <= ext_clk_d;
      end
   end

   // Trim goes straight to the oscillator, whose rate rises with the code.
   assign trim_value_o = trim_q;
   assign use_ext_clk_o = use_ext_q;
   assign rc_freq_sel_o = freq_q;
   assign osc_run_o = osc_run_q;
   assign ext_clk_o = ext_clk_q;
   assign core_halt_o = halt_q;
   assign core_reset_o = creset_q;
   assign irq_ack_o = ack_q;
   assign lowpower_mode_o = mode_q;
   assign reg_rdata_o = rdata_q;
endmodule : cts_top

/* File: cts_ext_src.sv */
`timescale 1ns/1ps
module cts_ext_src import cts_pkg::*; #(
   parameter int PIN_HALF = 3,
   parameter int TICK_PER = 4
) (
   // Clock.
   input wire logic ref_clk_i,
   // Clock pin and watchdog tick.
   output logic pin_o,
   output logic tick_o
);
   int pin_cnt = 0;
   int tick_cnt = 0;
   initial pin_o = 1'b0;
   initial tick_o = 1'b0;
   // The pin period is fixed, so no cycle-to-cycle step ever occurs.
   always @(posedge ref_clk_i) begin
      pin_cnt <= (pin_cnt == PIN_HALF - 1) ? 0 : pin_cnt + 1;
      if (pin_cnt == PIN_HALF - 1) pin_o <= ~pin_o;
   end
   // The watchdog tick is counted from ref_clk_i, one pulse every TICK_PER cycles.
   always @(posedge ref_clk_i) begin
      tick_cnt <= (tick_cnt == TICK_PER - 1) ? 0 : tick_cnt + 1;
      tick_o <= (tick_cnt == TICK_PER - 1);
   end
endmodule : cts_ext_src

/* File: cts_props.sv */
`timescale 1ns/1ps
module cts_props import cts_pkg::*; (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Inputs.
   input wire logic [3:0] clock_source_select_fuses_i,
   input wire logic [7:0] factory_cal_i,
   input wire logic osc_input_pin_i,
   input wire logic sleep_instr_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   // Outputs.
   input wire logic [7:0] reg_rdata_o,
   input wire logic [7:0] trim_value_o,
   input wire logic use_ext_clk_o,
   input wire logic [1:0] rc_freq_sel_o,
   input wire logic osc_run_o,
   input wire logic ext_clk_o,
   input wire logic core_halt_o,
   input wire logic core_reset_o,
   input wire logic irq_ack_o,
   input wire logic [2:0] lowpower_mode_o
);
   logic allow_q;
   logic [2:0] mode_q;
   logic take;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         allow_q <= 1'b0;
         mode_q <= 3'h0;
      end else if (reg_wr_i) begin
         if (reg_addr_i == CTS_ADDR_MCUCTL) begin
            allow_q <= reg_wdata_i[CTS_BIT_ALLOW];
            mode_q[1] <= reg_wdata_i[CTS_BIT_SEL_MID];
         end
         if (reg_addr_i == CTS_ADDR_MCUSTAT) begin
            mode_q[2] <= reg_wdata_i[CTS_BIT_SEL_HI];
         end
         if (reg_addr_i == CTS_ADDR_EXTCTL) begin
            mode_q[0] <= reg_wdata_i[CTS_BIT_SEL_LO];
         end
      end
   end
   assign take = sleep_instr_i && !core_halt_o && allow_q &&
      (mode_q inside {CTS_MODE_IDLE, CTS_MODE_PDOWN, CTS_MODE_STBY});
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   a_read_idle: assert property (
      !$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("rdata not 0");
   a_trim_read: assert property (
      reg_rd_i && reg_addr_i == CTS_ADDR_TRIM |=>
      reg_rdata_o == $past(trim_value_o)) else $error("trim read wrong");
   a_trim_write: assert property (
      reg_wr_i && reg_addr_i == CTS_ADDR_TRIM && !core_reset_o |=>
      trim_value_o == $past(reg_wdata_i)) else $error("trim write lost");
   a_cal_load: assert property (
      !rst_i && core_reset_o |=> trim_value_o == $past(factory_cal_i))
      else $error("calibration not loaded");
   a_src_held: assert property (
      !core_reset_o |-> use_ext_clk_o ==
      (clock_source_select_fuses_i == CTS_SRC_EXT)) else $error("ext sel");
   a_rc_freq: assert property (
      !core_reset_o && clock_source_select_fuses_i inside
      {[CTS_SRC_RC1:CTS_SRC_RC8]} |-> rc_freq_sel_o ==
      clock_source_select_fuses_i[1:0] - 2'd1) else $error("rc freq");
   a_ext_pass: assert property (
      $past(use_ext_clk_o, 4) && use_ext_clk_o |->
      ext_clk_o == $past(osc_input_pin_i, 3)) else $error("ext clock");
   a_sleep_take: assert property (
      take |=> core_halt_o && lowpower_mode_o == $past(mode_q))
      else $error("sleep not entered");
   a_sleep_refuse: assert property (
      sleep_instr_i && !core_halt_o && !take |=> !core_halt_o)
      else $error("sleep entered wrongly");
   a_pdown_osc: assert property (
      take && mode_q == CTS_MODE_PDOWN |=> ##1 !osc_run_o)
      else $error("osc runs in power-down");
   a_stby_osc: assert property (
      core_halt_o && lowpower_mode_o == CTS_MODE_STBY |-> osc_run_o)
      else $error("osc stopped in standby");
   a_ack_stall: assert property (
      irq_ack_o |-> $past(core_halt_o, 5) ##1 !irq_ack_o)
      else $error("wake stall short");
   c_pdown: cover property (take && mode_q == CTS_MODE_PDOWN);
   c_wake: cover property (irq_ack_o);
   c_refuse: cover property (sleep_instr_i && !core_halt_o && !take);
endmodule : cts_props
bind cts_top cts_props u_props (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .clock_source_select_fuses_i(clock_source_select_fuses_i),
   .factory_cal_i(factory_cal_i), .osc_input_pin_i(osc_input_pin_i),
   .sleep_instr_i(sleep_instr_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .trim_value_o(trim_value_o),
   .use_ext_clk_o(use_ext_clk_o), .rc_freq_sel_o(rc_freq_sel_o),
   .osc_run_o(osc_run_o), .ext_clk_o(ext_clk_o),
   .core_halt_o(core_halt_o), .core_reset_o(core_reset_o),
   .irq_ack_o(irq_ack_o), .lowpower_mode_o(lowpower_mode_o));

/* File: test_clock_source_trim_and_sleep_entry.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin \
   n_fail++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module test_clock_source_trim_and_sleep_entry import cts_pkg::*;
;
   localparam int TICK_PER = 4;
   localparam int SHORT = 5;
   localparam int LONG = 9;
   localparam logic [3:0] SRCS [5] = '{CTS_SRC_RC1, CTS_SRC_EXT,
      CTS_SRC_RC2, CTS_SRC_RC4, CTS_SRC_RC8};
   localparam logic [1:0] SUTS [5] = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h0};
   localparam logic [2:0] MODES [5] = '{CTS_MODE_IDLE, CTS_MODE_PDOWN,
      CTS_MODE_STBY, 3'h1, CTS_MODE_PDOWN};
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   cts_fuse_t fuse = '{CTS_DFLT_SRC, CTS_DFLT_SUT, 1'b0};
   cts_bus_t bus = '0;
   logic [7:0] factory_cal_i = 8'h00;
   logic sleep_instr_i = 1'b0;
   logic irq_i = 1'b0;
   logic pin, tick, use_ext, osc_run, ext_clk, halt, creset, ack, tk;
   logic [7:0] rdata, trim, got, ex;
   logic [1:0] freq, f;
   logic [2:0] mode, m;
   logic [31:0] rnd = 32'h7a86_3cba;
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   int n;
   int w;
   cts_top #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) uut (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .clock_source_select_fuses_i(fuse.src),
      .startup_time_fuses_i(fuse.startup_time_fuses),
      .oscillator_option_fuse_i(fuse.cap_opt),
      .factory_cal_i(factory_cal_i), .osc_input_pin_i(pin),
      .wdt_osc_tick_i(tick), .sleep_instr_i(sleep_instr_i),
      .irq_i(irq_i), .reg_addr_i(bus.addr), .reg_wdata_i(bus.wdata),
      .reg_wr_i(bus.wr), .reg_rd_i(bus.rd), .reg_rdata_o(rdata),
      .trim_value_o(trim), .use_ext_clk_o(use_ext),
      .rc_freq_sel_o(freq), .osc_run_o(osc_run), .ext_clk_o(ext_clk),
      .core_halt_o(halt), .core_reset_o(creset), .irq_ack_o(ack),
      .lowpower_mode_o(mode));
   cts_ext_src #(.PIN_HALF(3), .TICK_PER(TICK_PER)) src (
      .ref_clk_i(ref_clk_i), .pin_o(pin), .tick_o(tick));
   always #5 ref_clk_i = ~ref_clk_i;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic results();
      $display("checks %0d fails %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk_i);
      bus.wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk_i);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task automatic slp();
      @(posedge ref_clk_i);
      sleep_instr_i <= 1'b1;
      @(posedge ref_clk_i);
      sleep_instr_i <= 1'b0;
      #1;
   endtask : slp
   task automatic do_reset(input logic [3:0] s, input logic [1:0] t);
      int k;
      k = (t == CTS_SUT_SHORT) ? SHORT : (t == CTS_SUT_LONG) ? LONG : 0;
      rnd = lfsr(rnd);
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      fuse <= '{s, t, 1'b0};
      factory_cal_i <= rnd[7:0];
      repeat (5) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         #1 n++;
      end while (creset !== 1'b0 && n < 1000);
      w = (k == 0) ? int'(n == 2) : int'(n >= (k - 1) * TICK_PER + 2 &&
         n <= (k + 1) * TICK_PER + 4);
      `CHK("delay", 1, w)
      `CHK("trim_cal", rnd[7:0], trim)
      `CHK("ext_sel", s == CTS_SRC_EXT, use_ext)
   endtask : do_reset
   initial begin
      for (int i = 0; i < 5; i++) begin
         do_reset(SRCS[i], SUTS[i]);
         f = SRCS[i][1:0] - 2'd1;
         if (SRCS[i] != CTS_SRC_EXT) begin
            `CHK("freq", f, freq)
            rd(CTS_ADDR_STATE, got);
            `CHK("state", {6'h00, f}, got)
         end
         for (int a = 1; a < 4; a++) begin
            rd(a[3:0], got);
            `CHK("reg_reset", 8'h00, got)
         end
      end
      $display("test reset done");
      for (int k = 0; k < 8; k++) begin
         rnd = lfsr(rnd);
         ex = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : rnd[7:0];
         // No non-volatile write runs here, so full-range trim is safe.
         wr(CTS_ADDR_TRIM, ex);
         `CHK("trim_out", ex, trim)
         rd(CTS_ADDR_TRIM, got);
         `CHK("trim_rd", ex, got)
      end
      for (int a = 5; a < 16; a++) begin
         wr(a[3:0], 8'h5a);
         rd(a[3:0], got);
         `CHK("unmapped", 8'h00, got)
      end
      wr(CTS_ADDR_STATE, 8'hff);
      rd(CTS_ADDR_STATE, got);
      `CHK("state_ro", 8'h03, got)
      $display("test registers done");
      for (int j = 0; j < 5; j++) begin
         m = MODES[j];
         tk = (j < 4) && (m != 3'h1);
         wr(CTS_ADDR_MCUCTL, {2'b00, j != 4, m[1], 4'h0});
         wr(CTS_ADDR_MCUSTAT, {2'b00, m[2], 5'h00});
         wr(CTS_ADDR_EXTCTL, {m[0], 7'h00});
         slp();
         `CHK("halt", tk, halt)
         if (tk) begin
            `CHK("mode", m, mode)
            @(posedge ref_clk_i);
            #1 `CHK("osc_run", m != CTS_MODE_PDOWN, osc_run)
            @(posedge ref_clk_i);
            irq_i <= 1'b1;
            n = 0;
            do begin
               @(posedge ref_clk_i);
               #1 n++;
            end while (ack !== 1'b1 && n < 100);
            @(posedge ref_clk_i);
            irq_i <= 1'b0;
            w = (m == CTS_MODE_IDLE) ? 5 : 11;
            `CHK("wake", 1'b1, n >= w - 1 && n <= w + 1)
            `CHK("kept", ex, trim)
         end
      end
      $display("test sleep done");
      wr(CTS_ADDR_MCUCTL, 8'h30);
      slp();
      `CHK("pdown", 1'b1, halt)
      do_reset(CTS_SRC_RC1, CTS_SUT_NONE);
      `CHK("restart", 1'b0, halt)
      $display("test reset in sleep done");
      results();
   end
endmodule : test_clock_source_trim_and_sleep_entry
